// file: hw/acr_adc_ctrl.sv
// Converter control register bank with AHB-Lite slave and conversion sequencer.
//
// Summary of operation
// - Registers decode at base 0x40800000 plus each register offset.
// - Control at 0x00 resets zero; configuration at 0x04 resets 0x0000000C.
// - Read-only masked event status at 0x08, resetting to zero.
// - Writable event mask at 0x0C resets 0xF, all events masked.
// - Read-only two's complement conversion result at 0x14, reset zero.
// - Writable offset correction at 0x18 corrects the data of calibrated conversions only.
// - Converter state 0x20, upper limit 0x24 (0xFFFFFFF), lower 0x28.
// - Control bit 0 powers the analog part; set before any trigger.
// - Control bit 1 adds calibration to each conversion until disabled.
// - Writing control bit 6 clears calibration enable; bit reads zero.
// - Control bit 2 starts conversion when the analog part is powered.
// - Writing control bit 3 resets all registers; bit reads zero.
// - Writing control bit 4 stops conversion and powers off; reads zero.
// - With bit 5 set, results within limits raise the in-window flag.
// - Control bit 7 lets calibration overwrite the offset correction.
// - Control bit 8 enables the voice filter chain.
// - Control bit 9 enables DMA transfer requests.
// - Busy is set during conversion; configuration writes are then ignored.
// - Calibration end raises its done flag; with control bit 7 set it also stores the measured offset.
// - Flags at bits 0, 2, 3 set on events, clear on status read.
// - Mask bit one disables, zero enables, same positions as flags.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module acr_adc_ctrl (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        core_cal_done,
  input  wire logic [31:0] core_cal_offset,
  input  wire logic        core_data_valid,
  input  wire logic [31:0] core_data,
  output logic             analog_power,
  output logic             cal_phase,
  output logic             acq_phase,
  output logic             voice_filter_enable,
  output logic      [31:0] cfg_out,
  output logic             dma_req,
  output logic             busy
);

  acr_pkg::acr_state_s q;
  acr_pkg::acr_state_s n;
  acr_pkg::acr_state_s rst_v;
  logic                acc;
  logic                hit;
  logic                wr_ctl;
  logic                in_win;

  // The soft-reset image; the hresetn branch below loads the same values from its own literal.
  always_comb begin
    rst_v          = '0;
    rst_v.control  = acr_pkg::CONTROL_RST;
    rst_v.cfg      = acr_pkg::CFG_RST;
    rst_v.mask     = acr_pkg::MASK_RST;
    rst_v.upper    = acr_pkg::UPPER_RST;
    rst_v.lower    = acr_pkg::LOWER_RST;
    rst_v.result   = acr_pkg::ZERO_RST;
    rst_v.correction = acr_pkg::ZERO_RST;
    rst_v.phase    = acr_pkg::PH_IDLE;
    rst_v.rdy      = 1'b1;
  end

  // Address-phase acceptance; only whole-word transfers inside the window hit.
  assign acc = hsel & hready & htrans[1];
  assign hit = (haddr[31:acr_pkg::WIN_LSB] == acr_pkg::BASE_ADDR[31:acr_pkg::WIN_LSB])
               & (hsize == 3'h2);
  assign wr_ctl = q.dph_wr & (q.dph_addr == acr_pkg::OFF_CONTROL);
  // Inclusive signed window test on the stored result.
  assign in_win = ($signed(q.result) <= $signed(q.upper))
                  & ($signed(q.result) >= $signed(q.lower));

  // Next-state logic: bus writes first, then the sequencer, so that
  // hardware events win over a clear issued in the same cycle.
  always_comb begin
    n = q;
    n.dma_req = 1'b0;
    n.dph_wr  = 1'b0;

    // Data phase of a write: the word is on hwdata now.
    if (q.dph_wr) begin
      unique case (q.dph_addr)
        acr_pkg::OFF_CONTROL: begin
          n.control = hwdata & acr_pkg::CONTROL_WMASK;
          if (hwdata[acr_pkg::BIT_CALDIS]) begin
            n.control[acr_pkg::BIT_CALIB] = 1'b0;
          end
          if (hwdata[acr_pkg::BIT_STOP]) begin
            n.control[acr_pkg::BIT_POWER] = 1'b0;
            n.control[acr_pkg::BIT_TRIG]  = 1'b0;
          end
        end
        acr_pkg::OFF_CFG: begin
          // A running conversion keeps its settings.
          if (q.phase == acr_pkg::PH_IDLE) begin
            n.cfg = hwdata;
          end
        end
        acr_pkg::OFF_EVT_MASK: n.mask = hwdata[3:0];
        acr_pkg::OFF_CORRECTION: n.correction = hwdata;
        acr_pkg::OFF_UPPER: n.upper = hwdata;
        acr_pkg::OFF_LOWER: n.lower = hwdata;
        default: ;
      endcase
    end

    // Address phase: latch writes, read data comes out of a flop next cycle.
    if (acc) begin
      n.dph_wr   = hwrite & hit;
      n.dph_addr = haddr[5:0];
      n.rdata    = '0;
      if (hit & ~hwrite) begin
        unique case (haddr[5:0])
          acr_pkg::OFF_CONTROL: n.rdata = q.control;
          acr_pkg::OFF_CFG: n.rdata = q.cfg;
          acr_pkg::OFF_EVT_STATUS: begin
            n.rdata = {28'h0, q.flags & ~q.mask};
            n.flags = 4'h0;
          end
          acr_pkg::OFF_EVT_MASK: n.rdata = {28'h0, q.mask};
          acr_pkg::OFF_RESULT: n.rdata = q.result;
          acr_pkg::OFF_CORRECTION: n.rdata = q.correction;
          acr_pkg::OFF_CONV_STATE: n.rdata = {31'h0, q.phase != acr_pkg::PH_IDLE};
          acr_pkg::OFF_UPPER: n.rdata = q.upper;
          acr_pkg::OFF_LOWER: n.rdata = q.lower;
          default: n.rdata = '0;
        endcase
      end
    end

    // Conversion sequencer.
    unique case (q.phase)
      acr_pkg::PH_IDLE: begin
        if (q.control[acr_pkg::BIT_POWER] & q.control[acr_pkg::BIT_TRIG]) begin
          n.phase    = acr_pkg::PH_WAKE;
          n.cnt      = '0;
          n.cal_pass = q.control[acr_pkg::BIT_CALIB];
        end
      end
      acr_pkg::PH_WAKE: begin
        n.cnt = q.cnt + 16'h1;
        if (q.cnt == acr_pkg::WAKE_CYC - 16'h1) begin
          n.phase = q.cal_pass ? acr_pkg::PH_CAL : acr_pkg::PH_ACQ;
        end
      end
      acr_pkg::PH_CAL: begin
        if (core_cal_done) begin
          n.flags[acr_pkg::FLAG_CALDN] = 1'b1;
          if (q.control[acr_pkg::BIT_AUTOOFS]) begin
            n.correction = core_cal_offset;
          end
          n.phase = acr_pkg::PH_ACQ;
        end
      end
      acr_pkg::PH_ACQ: begin
        if (core_data_valid) begin
          // Correction uses the stored offset only when calibrating.
          n.result = q.cal_pass ? core_data - q.correction : core_data;
          n.phase  = acr_pkg::PH_ELAB;
        end
      end
      acr_pkg::PH_ELAB: begin
        n.flags[acr_pkg::FLAG_EOC] = 1'b1;
        if (q.control[acr_pkg::BIT_WINEN] & in_win) begin
          n.flags[acr_pkg::FLAG_WIN] = 1'b1;
        end
        n.dma_req = q.control[acr_pkg::BIT_DMAEN];
        if (q.cfg[acr_pkg::BIT_CONT] & n.control[acr_pkg::BIT_POWER]
            & n.control[acr_pkg::BIT_TRIG]) begin
          n.cal_pass = n.control[acr_pkg::BIT_CALIB];
          n.phase    = n.cal_pass ? acr_pkg::PH_CAL : acr_pkg::PH_ACQ;
        end else begin
          n.phase = acr_pkg::PH_IDLE;
          if (~q.cfg[acr_pkg::BIT_CONT]) begin
            n.control[acr_pkg::BIT_TRIG] = 1'b0;
          end
        end
      end
      default: n.phase = acr_pkg::PH_IDLE;
    endcase

    // Losing power aborts whatever conversion is running.
    if (~n.control[acr_pkg::BIT_POWER]) begin
      n.phase = acr_pkg::PH_IDLE;
    end

    // Soft reset wins over everything else written in the same cycle.
    if (wr_ctl & hwdata[acr_pkg::BIT_SWRST]) begin
      n = rst_v;
    end

    n.cal_on = n.phase == acr_pkg::PH_CAL;
    n.acq_on = n.phase == acr_pkg::PH_ACQ;
    n.busy   = n.phase != acr_pkg::PH_IDLE;
  end

  // One register stage for the whole state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{control: acr_pkg::CONTROL_RST, cfg: acr_pkg::CFG_RST,
             correction: acr_pkg::ZERO_RST, upper: acr_pkg::UPPER_RST,
             lower: acr_pkg::LOWER_RST, result: acr_pkg::ZERO_RST,
             flags: 4'h0, mask: acr_pkg::MASK_RST, phase: acr_pkg::PH_IDLE,
             cnt: 16'h0, cal_pass: 1'b0, cal_on: 1'b0, acq_on: 1'b0,
             dma_req: 1'b0, dph_wr: 1'b0, dph_addr: 6'h0, busy: 1'b0,
             rdata: 32'h0, rdy: 1'b1};
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state register.
  assign hrdata              = q.rdata;
  assign hreadyout           = q.rdy;
  assign hresp               = q.dph_wr & 1'b0;
  assign analog_power        = q.control[acr_pkg::BIT_POWER];
  assign cal_phase           = q.cal_on;
  assign acq_phase           = q.acq_on;
  assign voice_filter_enable = q.control[acr_pkg::BIT_VOICE];
  assign cfg_out             = q.cfg;
  assign dma_req             = q.dma_req;
  assign busy                = q.busy;

  // Checks on the sequencer and the register side effects.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_wake_bound: assert property (
    (q.phase == acr_pkg::PH_WAKE) |-> (q.cnt < acr_pkg::WAKE_CYC))
    else $error("wake phase ran past its settle count");

  chk_start_power: assert property (
    $rose(busy) |-> $past(q.control[acr_pkg::BIT_POWER]))
    else $error("conversion started without analog power");

  chk_caldis_clear: assert property (
    (wr_ctl && hwdata[acr_pkg::BIT_CALDIS] && !hwdata[acr_pkg::BIT_SWRST])
    |=> !q.control[acr_pkg::BIT_CALIB] && !q.control[acr_pkg::BIT_CALDIS])
    else $error("calibration disable strobe did not clear enable");

  chk_cfg_locked: assert property (
    (q.dph_wr && q.dph_addr == acr_pkg::OFF_CFG && busy) |=> $stable(q.cfg))
    else $error("configuration changed during a conversion");

  chk_soft_reset: assert property (
    (wr_ctl && hwdata[acr_pkg::BIT_SWRST])
    |=> q.cfg == acr_pkg::CFG_RST && q.mask == acr_pkg::MASK_RST
        && q.upper == acr_pkg::UPPER_RST && q.control == acr_pkg::CONTROL_RST)
    else $error("soft reset left a register off its reset value");

  chk_stop_off: assert property (
    (wr_ctl && hwdata[acr_pkg::BIT_STOP]) |=> !analog_power && !busy ##1 !busy)
    else $error("stop strobe did not halt and power off");

  chk_eoc_flag: assert property (
    (q.phase == acr_pkg::PH_ELAB && !(wr_ctl && hwdata[acr_pkg::BIT_SWRST]))
    |=> q.flags[acr_pkg::FLAG_EOC])
    else $error("end of conversion flag not raised");

  chk_window_flag: assert property (
    (q.phase == acr_pkg::PH_ELAB && q.control[acr_pkg::BIT_WINEN] && in_win
     && !(wr_ctl && hwdata[acr_pkg::BIT_SWRST])) |=> q.flags[acr_pkg::FLAG_WIN])
    else $error("in-window flag not raised");

  chk_cal_offset: assert property (
    (q.phase == acr_pkg::PH_CAL && core_cal_done && !q.dph_wr
     && q.control[acr_pkg::BIT_AUTOOFS])
    |=> q.correction == $past(core_cal_offset) && q.flags[acr_pkg::FLAG_CALDN])
    else $error("calibration result not stored");

  chk_dma_gate: assert property (
    dma_req |-> $past(q.control[acr_pkg::BIT_DMAEN]) && $past(q.phase == acr_pkg::PH_ELAB))
    else $error("dma request without enable or conversion end");

  chk_masked_read: assert property (
    (acc && hit && !hwrite && haddr[5:0] == acr_pkg::OFF_EVT_STATUS)
    |=> hrdata == {28'h0, $past(q.flags) & $past(q.mask) ^ $past(q.flags)})
    else $error("event status read not masked");

  // An idle configuration write stores the whole word.
  chk_cfg_write: assert property (
    (q.dph_wr && q.dph_addr == acr_pkg::OFF_CFG && !busy) |=> q.cfg == $past(hwdata))
    else $error("configuration write did not land");

  // Mask writes keep the four event bits of the word.
  chk_mask_write: assert property (
    (q.dph_wr && q.dph_addr == acr_pkg::OFF_EVT_MASK) |=> q.mask == $past(hwdata[3:0]))
    else $error("event mask write did not land");

  // The result only moves when a sample is taken or on a soft reset.
  chk_result_hold: assert property (
    (q.phase != acr_pkg::PH_ACQ && !(wr_ctl && hwdata[acr_pkg::BIT_SWRST]))
    |=> $stable(q.result))
    else $error("conversion result changed outside acquisition");

  // Software owns the correction word unless a calibration with control bit 7 set ends in the same cycle.
  chk_corr_write: assert property (
    (q.dph_wr && q.dph_addr == acr_pkg::OFF_CORRECTION
     && !(q.phase == acr_pkg::PH_CAL && core_cal_done)) |=> q.correction == $past(hwdata))
    else $error("offset correction write did not land");

  // Both limit words store whatever software writes.
  chk_upper_write: assert property (
    (q.dph_wr && q.dph_addr == acr_pkg::OFF_UPPER) |=> q.upper == $past(hwdata))
    else $error("upper limit write did not land");

  // The lower limit has no side effect on write either.
  chk_lower_write: assert property (
    (q.dph_wr && q.dph_addr == acr_pkg::OFF_LOWER) |=> q.lower == $past(hwdata))
    else $error("lower limit write did not land");

  // Without power the sequencer never leaves idle.
  chk_power_idle: assert property (
    !analog_power |-> !busy)
    else $error("converter busy while unpowered");

  // Calibration enable changes only through a control write.
  chk_calibration_enable_hold: assert property (
    !wr_ctl |=> $stable(q.control[acr_pkg::BIT_CALIB]))
    else $error("calibration enable changed by itself");

  // A conversion only starts from a set trigger bit.
  chk_trig_start: assert property (
    $rose(busy) |-> $past(q.control[acr_pkg::BIT_TRIG]))
    else $error("conversion started without trigger");

  // The settle wait ends on its last count.
  chk_wake_exit: assert property (
    (q.phase == acr_pkg::PH_WAKE && q.cnt == acr_pkg::WAKE_CYC - 16'h1)
    |=> q.phase != acr_pkg::PH_WAKE)
    else $error("wake phase outlived its settle count");

  // Strobe and reserved control bits never hold a one.
  chk_strobe_bits: assert property (
    (q.control & ~acr_pkg::CONTROL_WMASK) == 32'h0)
    else $error("strobe or reserved control bit stored");

  // The request toward the transfer engine lasts one cycle.
  chk_dma_pulse: assert property (
    dma_req |=> !dma_req)
    else $error("dma request longer than one cycle");

  // Busy tracks the sequencer exactly.
  chk_busy_phase: assert property (
    busy == (q.phase != acr_pkg::PH_IDLE))
    else $error("busy does not match the sequencer");

  // Calibration end raises its flag whatever the offset setting, unless a soft reset lands with it.
  chk_caldone_flag: assert property (
    (q.phase == acr_pkg::PH_CAL && core_cal_done && !(wr_ctl && hwdata[acr_pkg::BIT_SWRST]))
    |=> q.flags[acr_pkg::FLAG_CALDN])
    else $error("calibration done flag not raised");

  // A status read with no event in flight leaves every flag clear.
  chk_flag_clear: assert property (
    (acc && hit && !hwrite && haddr[5:0] == acr_pkg::OFF_EVT_STATUS
     && q.phase != acr_pkg::PH_ELAB && q.phase != acr_pkg::PH_CAL) |=> q.flags == 4'h0)
    else $error("status read did not clear the flags");

  // The end of conversion flag only rises out of the final phase.
  chk_eoc_source: assert property (
    $rose(q.flags[acr_pkg::FLAG_EOC]) |-> $past(q.phase == acr_pkg::PH_ELAB))
    else $error("end of conversion flag raised without a conversion");

endmodule

// file: hw/acr_pkg.sv
// Shared constants and state types for the converter control register block.
package acr_pkg;
  // Bus decode: the bank lives in a 64-byte window above the base address.
  localparam logic [31:0] BASE_ADDR      = 32'h4080_0000;
  localparam int          WIN_LSB        = 6;
  localparam logic [5:0]  OFF_CONTROL    = 6'h00;
  localparam logic [5:0]  OFF_CFG        = 6'h04;
  localparam logic [5:0]  OFF_EVT_STATUS = 6'h08;
  localparam logic [5:0]  OFF_EVT_MASK   = 6'h0c;
  localparam logic [5:0]  OFF_RESULT     = 6'h14;
  localparam logic [5:0]  OFF_CORRECTION = 6'h18;
  localparam logic [5:0]  OFF_CONV_STATE = 6'h20;
  localparam logic [5:0]  OFF_UPPER      = 6'h24;
  localparam logic [5:0]  OFF_LOWER      = 6'h28;

  // Values after reset.
  localparam logic [31:0] CONTROL_RST    = 32'h0000_0000;
  localparam logic [31:0] CFG_RST        = 32'h0000_000c;
  localparam logic [3:0]  MASK_RST       = 4'hf;
  localparam logic [31:0] UPPER_RST      = 32'h0fff_ffff;
  localparam logic [31:0] LOWER_RST      = 32'h0000_0000;
  localparam logic [31:0] ZERO_RST       = 32'h0000_0000;

  // Control bit positions.
  localparam int BIT_POWER   = 0;
  localparam int BIT_CALIB   = 1;
  localparam int BIT_TRIG    = 2;
  localparam int BIT_SWRST   = 3;
  localparam int BIT_STOP    = 4;
  localparam int BIT_WINEN   = 5;
  localparam int BIT_CALDIS  = 6;
  localparam int BIT_AUTOOFS = 7;
  localparam int BIT_VOICE   = 8;
  localparam int BIT_DMAEN   = 9;
  // Only these control bits hold a value; strobes and reserved bits do not.
  localparam logic [31:0] CONTROL_WMASK = 32'h0000_03a7;

  // Configuration continuous-mode bit, event flag bits and busy bit.
  localparam int BIT_CONT    = 11;
  localparam int FLAG_CALDN  = 0;
  localparam int FLAG_EOC    = 2;
  localparam int FLAG_WIN    = 3;
  localparam int BIT_BUSY    = 0;

  // Analog settle time when a conversion starts from idle; continuous restarts skip it.
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          WAKE_NS       = 6000;
  localparam logic [15:0] WAKE_CYC      =
    16'((WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    PH_IDLE, PH_WAKE, PH_CAL, PH_ACQ, PH_ELAB
  } acr_phase_e;

  typedef struct packed {
    logic [31:0] control;
    logic [31:0] cfg;
    logic [31:0] correction;
    logic [31:0] upper;
    logic [31:0] lower;
    logic [31:0] result;
    logic [3:0]  flags;
    logic [3:0]  mask;
    acr_phase_e  phase;
    logic [15:0] cnt;
    logic        cal_pass;
    logic        cal_on;
    logic        acq_on;
    logic        dma_req;
    logic        busy;
    logic        dph_wr;
    logic [5:0]  dph_addr;
    logic [31:0] rdata;
    logic        rdy;
  } acr_state_s;
endpackage

// file: dv/acr_testbench.sv
// Self-checking testbench for the converter control register block.
`timescale 1ns/1ps
module testbench;
  typedef struct { logic [31:0] v; string n; } acr_exp_s;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        cal_done = 1'b0;
  logic [31:0] cal_off = '0;
  logic        dvalid = 1'b0;
  logic [31:0] ddata = '0;
  logic [31:0] hrdata, cfg_out;
  logic        hreadyout, hresp, analog_power, cal_phase, acq_phase, voice_en, dma_req, busy;
  logic        rd_ph = 1'b0;
  logic [31:0] lfsr = 32'h745735be;
  logic [31:0] d, o, c;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  acr_exp_s    exp_q[$];
  logic [5:0]  offs[9] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h14, 6'h18, 6'h20, 6'h24, 6'h28};
  logic [31:0] rsts[9] = '{32'h0, 32'hc, 32'h0, 32'hf, 32'h0, 32'h0, 32'h0, 32'h0fff_ffff, 32'h0};

  acr_adc_ctrl uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .core_cal_done(cal_done), .core_cal_offset(cal_off), .core_data_valid(dvalid),
    .core_data(ddata), .analog_power(analog_power), .cal_phase(cal_phase),
    .acq_phase(acq_phase), .voice_filter_enable(voice_en), .cfg_out(cfg_out),
    .dma_req(dma_req), .busy(busy));

  // The clock toggles every half period of 10 ns.
  always #10 hclk = ~hclk;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string n);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic results();
    if (err_total == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One single word transfer; called just after a rising edge, holds each phase until ready.
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] v, input string n);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    if (!wr) exp_q.push_back('{v, n});
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    if (wr) hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hwdata <= ~v;
  endtask

  task automatic wr(input logic [5:0] off, input logic [31:0] v);
    xfer(1'b1, acr_pkg::BASE_ADDR | 32'(off), v, "");
  endtask

  task automatic rd(input logic [5:0] off, input logic [31:0] v, input string n);
    xfer(1'b0, acr_pkg::BASE_ADDR | 32'(off), v, n);
  endtask

  // Waits a bounded number of edges for a design flag; the caller's check after it catches a miss.
  task automatic wait_hi(ref logic s, input int lim);
    for (int i = 0; i < lim && s !== 1'b1; i++) @(posedge hclk);
  endtask

  // Hands one core sample over for one cycle, then drives its inverse onto the data bus and holds it.
  task automatic sample(input logic [31:0] v);
    wait_hi(acq_phase, 400);
    chk(acq_phase, 1'b1, "acq_phase");
    ddata  <= v;
    dvalid <= 1'b1;
    @(posedge hclk);
    dvalid <= 1'b0;
    ddata  <= ~v;
  endtask

  // Read data stand in the cycle after the address phase; the oldest note is compared then.
  always @(posedge hclk) begin : mon
    acr_exp_s e;
    if (rd_ph && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk(hrdata, e.v, e.n);
      chk(hresp, 1'b0, "hresp");
    end
    rd_ph <= hresetn & hsel & hreadyout & htrans[1] & ~hwrite;
  end

  // A hang is cut short well above the longest expected run.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      err_total++;
      results();
    end
  end

  initial begin
    repeat (10) @(posedge hclk);
    chk(cfg_out, acr_pkg::CFG_RST, "cfg_out in reset");
    hresetn <= 1'b1;
    for (int i = 0; i < 9; i++) rd(offs[i], rsts[i], "reset value");
    rd(6'h10, 32'h0, "unmapped");
    xfer(1'b0, 32'h4080_0040, 32'h0, "outside bank");
    // Configuration, correction and limit words read back; result and state words ignore writes.
    foreach (offs[i]) begin
      lfsr = nxt(lfsr);
      wr(offs[i], lfsr);
      if (offs[i] == 6'h04 || offs[i] == 6'h18 || offs[i] >= 6'h24) begin
        rd(offs[i], lfsr, "stored word");
      end else if (offs[i] == 6'h14 || offs[i] == 6'h20) begin
        rd(offs[i], 32'h0, "read-only word");
      end
    end
    wr(6'h00, 32'h0000_0058);
    rd(6'h00, 32'h0, "strobes read zero");
    // Trigger without power must not start anything.
    wr(6'h00, 32'h0000_0004);
    repeat (3) @(posedge hclk);
    chk(busy, 1'b0, "busy unpowered");
    // Continuous conversion, window on with both limits equal to the sample.
    lfsr = nxt(lfsr);
    d = lfsr;
    c = 32'h0000_0a5c;
    wr(6'h04, c);
    wr(6'h24, d);
    wr(6'h28, d);
    wr(6'h0c, 32'h0);
    wr(6'h00, 32'h0000_0325);
    // The write lands at the last edge of the task; busy follows one edge later.
    repeat (2) @(posedge hclk);
    chk(analog_power, 1'b1, "analog_power");
    chk(voice_en, 1'b1, "voice_filter_enable");
    chk(busy, 1'b1, "busy");
    wr(6'h04, ~c);
    rd(6'h20, 32'h1, "state busy");
    sample(d);
    wait_hi(dma_req, 5);
    chk(dma_req, 1'b1, "dma_req");
    @(posedge hclk);
    chk(dma_req, 1'b0, "dma_req pulse");
    rd(6'h14, d, "result");
    rd(6'h08, 32'hc, "status window");
    rd(6'h08, 32'h0, "status cleared");
    rd(6'h04, c, "cfg kept while busy");
    chk(cfg_out, c, "cfg_out");
    // Continuous mode runs on until software drops the trigger, then goes idle.
    chk(busy, 1'b1, "busy continuous");
    wr(6'h00, 32'h0000_0321);
    sample(~d);
    repeat (3) @(posedge hclk);
    chk(busy, 1'b0, "busy after trigger cleared");
    rd(6'h14, ~d, "continuous result");
    rd(6'h08, 32'h4, "status outside window");
    wr(6'h04, c ^ 32'h0000_0800);
    // Calibrated conversion with offset update, end-of-conversion masked.
    lfsr = nxt(lfsr);
    o = lfsr;
    lfsr = nxt(lfsr);
    d = lfsr;
    wr(6'h0c, 32'h4);
    wr(6'h00, 32'h0000_0087);
    wait_hi(cal_phase, 400);
    chk(cal_phase, 1'b1, "cal_phase");
    cal_off  <= o;
    cal_done <= 1'b1;
    @(posedge hclk);
    cal_done <= 1'b0;
    cal_off  <= ~o;
    sample(d);
    wait_hi(dma_req, 5);
    chk(dma_req, 1'b0, "dma_req disabled");
    repeat (2) @(posedge hclk);
    rd(6'h18, o, "offset updated");
    rd(6'h14, d - o, "corrected result");
    rd(6'h08, 32'h1, "status masked");
    rd(6'h00, 32'h0000_0083, "calibration kept");
    wr(6'h00, 32'h0000_0041);
    rd(6'h00, 32'h0000_0001, "calibration off");
    // Stop strobe in mid-wake aborts and powers down.
    wr(6'h00, 32'h0000_0005);
    wr(6'h00, 32'h0000_0011);
    @(posedge hclk);
    chk(busy, 1'b0, "busy after stop");
    chk(analog_power, 1'b0, "power after stop");
    // Soft reset returns every register to its reset value.
    wr(6'h24, 32'h1234_5678);
    wr(6'h00, 32'h0000_0008);
    for (int i = 0; i < 9; i++) rd(offs[i], rsts[i], "after soft reset");
    repeat (3) @(posedge hclk);
    results();
  end
endmodule
